// ==== pkg/irq_ctrl_pkg.sv ====
// Shared constants and carrier types of the interrupt priority controller
package irq_ctrl_pkg;

    // Register indices; byte address is four times the index
    localparam logic [7:0] IDX_TIMER_CONTROL  = 8'h88;
    localparam logic [7:0] IDX_ENABLE_MAIN    = 8'hA8;
    localparam logic [7:0] IDX_ENABLE_AUX     = 8'hA9;
    localparam logic [7:0] IDX_FLAG_AUX       = 8'hAA;
    localparam logic [7:0] IDX_PRIORITY_MAIN  = 8'hB8;
    localparam logic [7:0] IDX_PRIORITY_AUX   = 8'hB9;
    localparam logic [7:0] IDX_PERIPH_FLAGS   = 8'hC0;
    localparam logic [7:0] IDX_ENABLE_SET     = 8'hD0;
    localparam logic [7:0] IDX_ENABLE_CLR     = 8'hD1;
    localparam logic [7:0] IDX_STATUS         = 8'hD2;

    localparam logic [7:0] REG_RESET          = 8'h00;

    // int_enable_main fields
    localparam int GIE_BIT        = 7;
    localparam int ENABLE_MAIN_W  = 6;
    // Bit 3 of the aux enable, aux priority and aux flag registers
    localparam int CONV_BIT       = 3;
    // timer_control_reg fields
    localparam int TC_TF1         = 7;
    localparam int TC_TF0         = 5;
    localparam int TC_IE1         = 3;
    localparam int TC_IT1         = 2;
    localparam int TC_IE0         = 1;
    localparam int TC_IT0         = 0;
    // Peripheral flag register fields
    localparam int PF_RX          = 0;
    localparam int PF_TX          = 1;
    localparam int PF_T2OVF       = 2;
    localparam int PF_T2EXT       = 3;

    // Source numbers, natural order, 0 ranks first
    localparam int NUM_SRC        = 7;
    localparam logic [2:0] SRC_EXT0   = 3'h0;
    localparam logic [2:0] SRC_TIMER0 = 3'h1;
    localparam logic [2:0] SRC_EXT1   = 3'h2;
    localparam logic [2:0] SRC_TIMER1 = 3'h3;
    localparam logic [2:0] SRC_SERIAL = 3'h4;
    localparam logic [2:0] SRC_TIMER2 = 3'h5;
    localparam logic [2:0] SRC_CONV   = 3'h6;
    localparam logic [2:0] SRC_NONE   = 3'h7;

    localparam logic [NUM_SRC-1:0][15:0] VECTOR_TABLE = {
        16'h004B, 16'h002B, 16'h0023, 16'h001B, 16'h0013, 16'h000B, 16'h0003
    };

    // Request presented to the processor core
    typedef struct packed {
        logic        req;
        logic        high;
        logic [2:0]  src;
        logic [15:0] vector;
    } irq_out_s;

    // One-cycle event strobes from on-chip peripherals
    typedef struct packed {
        logic timer0_overflow;
        logic timer1_overflow;
        logic timer2_overflow;
        logic receive_done;
        logic transmit_done;
        logic conv_done;
    } periph_events_s;

endpackage : irq_ctrl_pkg

// ==== rtl/interrupt_priority_controller.sv ====
// Interrupt priority controller with APB register access and core handshake
`timescale 1ns/1ps

module interrupt_priority_controller
    import irq_ctrl_pkg::*;
#(
    parameter int ADDR_W = 12
) (
    input  wire logic           sys_clk,
    input  wire logic           sys_rst,
    input  wire logic           psel,
    input  wire logic           penable,
    input  wire logic           pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]    pwdata,
    output logic                pready,
    output logic [31:0]         prdata,
    output logic                pslverr,
    input  wire logic           ext_request_pin0,
    input  wire logic           ext_request_pin1,
    input  wire logic           timer2_capture_pin,
    input  wire periph_events_s events,
    input  wire logic           timer0_mode3,
    output irq_out_s            irq_out,
    input  wire logic           irq_ack,
    input  wire logic           irq_return
);

    logic [7:0]  int_enable_main_reg;
    logic [7:0]  int_enable_aux_reg;
    logic [7:0]  priority_main_reg;
    logic [7:0]  priority_aux_reg;
    logic        ext0_pending_reg, ext1_pending_reg;
    logic        ext0_edge_select_reg, ext1_edge_select_reg;
    logic        timer0_overflow_flag_reg, timer1_overflow_flag_reg;
    logic        timer2_overflow_flag_reg, timer2_external_flag_reg;
    logic        receive_complete_flag_reg, transmit_complete_flag_reg;
    logic        conv_done_flag_reg;
    logic        in_service_high_reg, in_service_low_reg;
    logic [2:0]  pin_meta_reg, pin_sync_reg, pin_prev_reg;
    logic [31:0] prdata_reg;
    irq_out_s    irq_reg, irq_next;

    // Lowest set bit wins: natural order among one level
    function automatic logic [2:0] first_set(input logic [NUM_SRC-1:0] m);
        logic [2:0] r;
        r = SRC_NONE;
        for (int i = NUM_SRC - 1; i >= 0; i--) begin
            if (m[i]) begin
                r = 3'(i);
            end
        end
        return r;
    endfunction : first_set

    // Read decode shared by the data path and the error answer
    function automatic logic [32:0] read_value(input logic [ADDR_W-1:0] a);
        logic [7:0] d;
        logic       hit;
        d   = 8'h00;
        hit = (a[1:0] == 2'b00) && (a[ADDR_W-1:10] == '0);
        case (a[9:2])
            IDX_TIMER_CONTROL: begin
                d[TC_TF1] = timer1_overflow_flag_reg;
                d[TC_TF0] = timer0_overflow_flag_reg;
                d[TC_IE1] = ext1_pending_reg;
                d[TC_IT1] = ext1_edge_select_reg;
                d[TC_IE0] = ext0_pending_reg;
                d[TC_IT0] = ext0_edge_select_reg;
            end
            IDX_ENABLE_MAIN, IDX_ENABLE_SET, IDX_ENABLE_CLR: d = int_enable_main_reg;
            IDX_ENABLE_AUX:    d = int_enable_aux_reg;
            IDX_FLAG_AUX:      d[CONV_BIT] = conv_done_flag_reg;
            IDX_PRIORITY_MAIN: d = priority_main_reg;
            IDX_PRIORITY_AUX:  d = priority_aux_reg;
            IDX_PERIPH_FLAGS: begin
                d[PF_RX]    = receive_complete_flag_reg;
                d[PF_TX]    = transmit_complete_flag_reg;
                d[PF_T2OVF] = timer2_overflow_flag_reg;
                d[PF_T2EXT] = timer2_external_flag_reg;
            end
            IDX_STATUS: d = {in_service_high_reg, in_service_low_reg, 2'b00,
                             irq_reg.req, irq_reg.src};
            default: hit = 1'b0;
        endcase
        return {hit, 24'h000000, d};
    endfunction : read_value

    // Bus decode
    logic       setup_phase, wr_en;
    logic [7:0] wr_idx, wr_byte;
    logic [32:0] rd_setup, rd_access;
    assign setup_phase = psel && !penable;
    // A process, not an assign: the function reads registers that are not its arguments
    always_comb begin
        rd_setup  = read_value(paddr);
        rd_access = rd_setup;
    end
    assign wr_en       = psel && penable && pwrite && rd_access[32];
    assign wr_idx      = paddr[9:2];
    assign wr_byte     = pwdata[7:0];

    // Zero-wait slave; read data is captured in the setup cycle
    assign pready  = 1'b1;
    assign prdata  = prdata_reg;
    assign pslverr = psel && penable && !rd_access[32];
    assign irq_out = irq_reg;

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            prdata_reg <= 32'h00000000;
        end else if (setup_phase && !pwrite) begin
            prdata_reg <= {24'h000000, rd_setup[7:0]};
        end
    end

    logic w_tc, w_pf, w_fa;
    assign w_tc = wr_en && (wr_idx == IDX_TIMER_CONTROL);
    assign w_pf = wr_en && (wr_idx == IDX_PERIPH_FLAGS);
    assign w_fa = wr_en && (wr_idx == IDX_FLAG_AUX);

    // Enable and priority registers
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            int_enable_main_reg <= REG_RESET;
            int_enable_aux_reg  <= REG_RESET;
        end else if (wr_en) begin
            case (wr_idx)
                IDX_ENABLE_MAIN: int_enable_main_reg <= wr_byte & 8'hBF;
                // Single-bit changes without read-modify-write races
                IDX_ENABLE_SET:  int_enable_main_reg <= (int_enable_main_reg | wr_byte) & 8'hBF;
                IDX_ENABLE_CLR:  int_enable_main_reg <= int_enable_main_reg & ~wr_byte;
                IDX_ENABLE_AUX:  int_enable_aux_reg  <= wr_byte & 8'h08;
                default: ;
            endcase
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            priority_main_reg <= REG_RESET;
            priority_aux_reg  <= REG_RESET;
        end else if (wr_en && wr_idx == IDX_PRIORITY_MAIN) begin
            priority_main_reg <= wr_byte & 8'h3F;
        end else if (wr_en && wr_idx == IDX_PRIORITY_AUX) begin
            priority_aux_reg  <= wr_byte & 8'h08;
        end
    end

    // Pin synchronisers; edge detect only looks past the second stage
    logic [2:0] pin_fall;
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            pin_meta_reg <= 3'h7;
            pin_sync_reg <= 3'h7;
            pin_prev_reg <= 3'h7;
        end else begin
            pin_meta_reg <= {timer2_capture_pin, ext_request_pin1, ext_request_pin0};
            pin_sync_reg <= pin_meta_reg;
            pin_prev_reg <= pin_sync_reg;
        end
    end
    assign pin_fall = pin_prev_reg & ~pin_sync_reg;

    // Service acknowledge of the presented source
    logic       ack_take;
    logic [NUM_SRC-1:0] serv;
    assign ack_take = irq_ack && irq_reg.req;
    always_comb begin
        serv = '0;
        if (ack_take) begin
            serv[irq_reg.src] = 1'b1;
        end
    end

    // External request flags; a hardware set always beats a clear
    logic ext0_set, ext1_set;
    assign ext0_set = ext0_edge_select_reg ? pin_fall[0] : !pin_sync_reg[0];
    assign ext1_set = ext1_edge_select_reg ? pin_fall[1] : !pin_sync_reg[1];
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            ext0_pending_reg     <= 1'b0;
            ext1_pending_reg     <= 1'b0;
            ext0_edge_select_reg <= 1'b0;
            ext1_edge_select_reg <= 1'b0;
        end else begin
            if (w_tc) begin
                ext0_edge_select_reg <= wr_byte[TC_IT0];
                ext1_edge_select_reg <= wr_byte[TC_IT1];
                ext0_pending_reg     <= wr_byte[TC_IE0] | ext0_set;
                ext1_pending_reg     <= wr_byte[TC_IE1] | ext1_set;
            end else begin
                ext0_pending_reg <= ext0_set | (ext0_pending_reg &
                                    !(serv[SRC_EXT0] && ext0_edge_select_reg));
                ext1_pending_reg <= ext1_set | (ext1_pending_reg &
                                    !(serv[SRC_EXT1] && ext1_edge_select_reg));
            end
        end
    end

    // Timer 0/1 overflow flags; timer 0 in mode 3 keeps its flag on service
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            timer0_overflow_flag_reg <= 1'b0;
            timer1_overflow_flag_reg <= 1'b0;
        end else if (w_tc) begin
            timer0_overflow_flag_reg <= wr_byte[TC_TF0] | events.timer0_overflow;
            timer1_overflow_flag_reg <= wr_byte[TC_TF1] | events.timer1_overflow;
        end else begin
            timer0_overflow_flag_reg <= events.timer0_overflow | (timer0_overflow_flag_reg &
                                        !(serv[SRC_TIMER0] && !timer0_mode3));
            timer1_overflow_flag_reg <= events.timer1_overflow |
                                        (timer1_overflow_flag_reg & !serv[SRC_TIMER1]);
        end
    end

    // Serial and timer 2 flags are left alone by service
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            receive_complete_flag_reg  <= 1'b0;
            transmit_complete_flag_reg <= 1'b0;
            timer2_overflow_flag_reg   <= 1'b0;
            timer2_external_flag_reg   <= 1'b0;
        end else if (w_pf) begin
            receive_complete_flag_reg  <= wr_byte[PF_RX] | events.receive_done;
            transmit_complete_flag_reg <= wr_byte[PF_TX] | events.transmit_done;
            timer2_overflow_flag_reg   <= wr_byte[PF_T2OVF] | events.timer2_overflow;
            timer2_external_flag_reg   <= wr_byte[PF_T2EXT] | pin_fall[2];
        end else begin
            receive_complete_flag_reg  <= receive_complete_flag_reg | events.receive_done;
            transmit_complete_flag_reg <= transmit_complete_flag_reg | events.transmit_done;
            timer2_overflow_flag_reg   <= timer2_overflow_flag_reg | events.timer2_overflow;
            timer2_external_flag_reg   <= timer2_external_flag_reg | pin_fall[2];
        end
    end

    // Converter flag
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            conv_done_flag_reg <= 1'b0;
        end else if (w_fa) begin
            conv_done_flag_reg <= wr_byte[CONV_BIT] | events.conv_done;
        end else begin
            conv_done_flag_reg <= events.conv_done |
                                  (conv_done_flag_reg & !serv[SRC_CONV]);
        end
    end

    // Arbitration
    logic               gie;
    logic [NUM_SRC-1:0] pend, enab, prio, act, act_hi, act_lo;
    assign gie  = int_enable_main_reg[GIE_BIT];
    assign pend = {conv_done_flag_reg,
                   timer2_overflow_flag_reg | timer2_external_flag_reg,
                   receive_complete_flag_reg | transmit_complete_flag_reg,
                   timer1_overflow_flag_reg, ext1_pending_reg,
                   timer0_overflow_flag_reg, ext0_pending_reg};
    assign enab = {int_enable_aux_reg[CONV_BIT],
                   int_enable_main_reg[ENABLE_MAIN_W-1:0]};
    assign prio = {priority_aux_reg[CONV_BIT],
                   priority_main_reg[ENABLE_MAIN_W-1:0]};
    assign act    = pend & enab & {NUM_SRC{gie}};
    assign act_hi = act & prio;
    assign act_lo = act & ~prio;

    always_comb begin
        irq_next      = '0;
        irq_next.src  = SRC_NONE;
        if ((|act_hi) && !in_service_high_reg) begin
            irq_next.req  = 1'b1;
            irq_next.high = 1'b1;
            irq_next.src  = first_set(act_hi);
        end else if ((|act_lo) && !in_service_high_reg && !in_service_low_reg) begin
            irq_next.req  = 1'b1;
            irq_next.src  = first_set(act_lo);
        end
        if (irq_next.req) begin
            irq_next.vector = VECTOR_TABLE[irq_next.src];
        end
        // Withdraw for a cycle after acceptance so the new in-service state is seen
        if (ack_take) begin
            irq_next.req = 1'b0;
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            irq_reg <= '0;
        end else begin
            irq_reg <= irq_next;
        end
    end

    // In-service levels; a return retires the higher active level first
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            in_service_high_reg <= 1'b0;
            in_service_low_reg  <= 1'b0;
        end else if (ack_take) begin
            if (irq_reg.high) begin
                in_service_high_reg <= 1'b1;
            end else begin
                in_service_low_reg  <= 1'b1;
            end
        end else if (irq_return) begin
            if (in_service_high_reg) begin
                in_service_high_reg <= 1'b0;
            end else begin
                in_service_low_reg  <= 1'b0;
            end
        end
    end

    // Checks
    property p_vector_table;
        @(posedge sys_clk) disable iff (sys_rst)
        irq_out.req && irq_out.src == SRC_EXT1 |-> irq_out.vector == 16'h0013;
    endproperty
    a_vector_table: assert property (p_vector_table) else $error("ext1 vector wrong");

    property p_conv_vector;
        @(posedge sys_clk) disable iff (sys_rst)
        irq_out.req && irq_out.src == SRC_CONV |-> irq_out.vector == 16'h004B;
    endproperty
    a_conv_vector: assert property (p_conv_vector) else $error("conv vector wrong");

    property p_gie_blocks;
        @(posedge sys_clk) disable iff (sys_rst)
        !gie && !$past(gie) |-> !irq_out.req;
    endproperty
    a_gie_blocks: assert property (p_gie_blocks) else $error("request with gie clear");

    property p_ack_in_service;
        @(posedge sys_clk) disable iff (sys_rst)
        irq_ack && irq_out.req && !irq_out.high |=> in_service_low_reg && !irq_out.req;
    endproperty
    a_ack_in_service: assert property (p_ack_in_service) else $error("no in-service");

    property p_return_clears;
        @(posedge sys_clk) disable iff (sys_rst)
        irq_return && !irq_ack && in_service_high_reg |=> !in_service_high_reg;
    endproperty
    a_return_clears: assert property (p_return_clears) else $error("return ignored");

    property p_no_same_level;
        @(posedge sys_clk) disable iff (sys_rst)
        in_service_low_reg ##1 in_service_low_reg |-> !irq_out.req || irq_out.high;
    endproperty
    a_no_same_level: assert property (p_no_same_level) else $error("same level nested");

    property p_high_first;
        @(posedge sys_clk) disable iff (sys_rst)
        (|act_hi) && !in_service_high_reg && !ack_take |=> irq_out.req && irq_out.high;
    endproperty
    a_high_first: assert property (p_high_first) else $error("high level lost");

    property p_order;
        @(posedge sys_clk) disable iff (sys_rst)
        irq_out.req && irq_out.src == SRC_TIMER0
        |-> !($past(act[0]) && ($past(prio[0]) == $past(prio[1])));
    endproperty
    a_order: assert property (p_order) else $error("natural order broken");

    property p_level_kept;
        @(posedge sys_clk) disable iff (sys_rst)
        serv[SRC_EXT0] && !ext0_edge_select_reg && !w_tc |=> ext0_pending_reg;
    endproperty
    a_level_kept: assert property (p_level_kept) else $error("level flag cleared");

    property p_t2_kept;
        @(posedge sys_clk) disable iff (sys_rst)
        serv[SRC_TIMER2] && timer2_overflow_flag_reg && !w_pf ##1 !w_pf
        |-> timer2_overflow_flag_reg;
    endproperty
    a_t2_kept: assert property (p_t2_kept) else $error("timer 2 flag cleared");

    property p_conv_cleared;
        @(posedge sys_clk) disable iff (sys_rst)
        serv[SRC_CONV] && !events.conv_done && !w_fa |=> !conv_done_flag_reg;
    endproperty
    a_conv_cleared: assert property (p_conv_cleared) else $error("conv flag kept");

    property p_capture_edge;
        @(posedge sys_clk) disable iff (sys_rst)
        pin_fall[2] |=> timer2_external_flag_reg;
    endproperty
    a_capture_edge: assert property (p_capture_edge) else $error("capture edge lost");

endmodule : interrupt_priority_controller

// ==== tb/core_model.sv ====
// Behavioural processor core that accepts requests and returns from service
`timescale 1ns/1ps

module core_model
    import irq_ctrl_pkg::*;
(
    input  wire logic       sys_clk,
    input  wire logic       sys_rst,
    input  wire irq_out_s   irq_out,
    input  wire logic [3:0] ack_delay,
    output logic            irq_ack,
    output logic            irq_return
);
    logic [3:0] cnt;
    logic       busy;

    // A busy core never acks, so nesting is not exercised here
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            irq_ack <= 1'b0;
            irq_return <= 1'b0;
            busy <= 1'b0;
            cnt <= 4'h0;
        end else begin
            irq_ack <= 1'b0;
            irq_return <= 1'b0;
            cnt <= (busy || irq_out.req) ? cnt + 4'h1 : 4'h0;
            if (!busy && irq_out.req && cnt >= ack_delay) begin
                irq_ack <= 1'b1;
                busy <= 1'b1;
                cnt <= 4'h0;
            end
            if (busy && cnt == 4'h6) begin
                irq_return <= 1'b1;
                busy <= 1'b0;
                cnt <= 4'h0;
            end
        end
    end
endmodule : core_model

// ==== tb/interrupt_priority_controller_tb.sv ====
// Self-checking bench for the interrupt priority controller
`timescale 1ns/1ps

module interrupt_priority_controller_tb
    import irq_ctrl_pkg::*;
;
    logic sys_clk = 1'b0, sys_rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, err, irq_ack, irq_return;
    logic [3:0] ack_delay = 4'h0;
    periph_events_s events = '0;
    irq_out_s irq_out, irq_seen;
    logic pin0 = 1'b1, pin1 = 1'b1, pin2 = 1'b1, mode3 = 1'b0;
    int fail_count = 0, cmp_count = 0;
    logic [7:0] f_idx [7] = '{8'h88, 8'h88, 8'h88, 8'h88, 8'hC0, 8'hC0, 8'hAA};
    logic [7:0] f_set [7] = '{8'h07, 8'h25, 8'h0D, 8'h85, 8'h01, 8'h04, 8'h08};
    logic [7:0] f_left [7] = '{8'h05, 8'h05, 8'h05, 8'h05, 8'h01, 8'h04, 8'h00};
    logic [15:0] vec [7] = '{16'h0003, 16'h000B, 16'h0013, 16'h001B, 16'h0023, 16'h002B, 16'h004B};

    interrupt_priority_controller #(.ADDR_W(12)) i_dut (.sys_clk(sys_clk), .sys_rst(sys_rst),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pready(pready), .prdata(prdata), .pslverr(pslverr), .ext_request_pin0(pin0),
        .ext_request_pin1(pin1), .timer2_capture_pin(pin2), .events(events),
        .timer0_mode3(mode3), .irq_out(irq_out), .irq_ack(irq_ack), .irq_return(irq_return));
    core_model i_core (.sys_clk(sys_clk), .sys_rst(sys_rst), .irq_out(irq_out),
        .ack_delay(ack_delay), .irq_ack(irq_ack), .irq_return(irq_return));

    initial begin
        forever #5 sys_clk = ~sys_clk;
    end

    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask : check

    // Called just after a rising edge; holds the request until pready is sampled high
    task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {2'b00, idx, 2'b00};
        pwdata <= {24'h0, wd};
        @(posedge sys_clk);
        penable <= 1'b1;
        do begin
            @(posedge sys_clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            fail_count++;
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge sys_clk);
    endtask : apb

    task automatic wait_sig(input logic want_req);
        int n;
        n = 0;
        do begin
            @(negedge sys_clk);
            n++;
        end while ((want_req ? irq_out.req : irq_return) !== 1'b1 && n < 60);
        // Captured on the falling edge, while the registered request stands
        irq_seen = irq_out;
        check("wait_sig", 32'h1, {31'h0, want_req ? irq_out.req : irq_return});
        @(posedge sys_clk);
    endtask : wait_sig

    task automatic test_reset;
        apb(1'b0, IDX_ENABLE_MAIN, 8'h00);
        check("enable_main", 32'h0, rd);
        apb(1'b0, IDX_ENABLE_AUX, 8'h00);
        check("enable_aux", 32'h0, rd);
        apb(1'b0, 8'hFF, 8'h00);
        check("unmapped_err", 32'h1, {31'h0, err});
        $display("test reset done");
    endtask : test_reset

    task automatic test_vectors;
        apb(1'b1, IDX_ENABLE_MAIN, 8'hBF);
        apb(1'b1, IDX_ENABLE_AUX, 8'h08);
        for (int i = 0; i < 7; i++) begin
            apb(1'b1, f_idx[i], f_set[i]);
            wait_sig(1'b1);
            check("vector", {16'h0, vec[i]}, {16'h0, irq_seen.vector});
            check("src", i, {29'h0, irq_seen.src});
            wait_sig(1'b0);
            apb(1'b0, f_idx[i], 8'h00);
            check("flag_after", {24'h0, f_left[i]}, rd);
            apb(1'b1, f_idx[i], 8'h00);
        end
        $display("test vectors done");
    endtask : test_vectors

    task automatic test_priority;
        logic seen;
        seen = 1'b0;
        ack_delay <= 4'h5;
        apb(1'b1, IDX_ENABLE_MAIN, 8'h3F);
        apb(1'b1, IDX_PRIORITY_MAIN, 8'h08);
        apb(1'b1, IDX_TIMER_CONTROL, 8'h87);
        repeat (10) begin
            @(negedge sys_clk);
            seen = seen | irq_out.req;
        end
        check("req_no_gie", 32'h0, {31'h0, seen});
        @(posedge sys_clk);
        apb(1'b1, IDX_ENABLE_SET, 8'h80);
        apb(1'b0, IDX_ENABLE_MAIN, 8'h00);
        check("enable_main_set", 32'hBF, rd);
        wait_sig(1'b1);
        check("high_first", {29'h0, SRC_TIMER1}, {29'h0, irq_seen.src});
        check("high_level", 32'h1, {31'h0, irq_seen.high});
        wait_sig(1'b0);
        wait_sig(1'b1);
        check("low_next", {29'h0, SRC_EXT0}, {29'h0, irq_seen.src});
        wait_sig(1'b0);
        apb(1'b1, IDX_ENABLE_CLR, 8'h80);
        apb(1'b0, IDX_ENABLE_MAIN, 8'h00);
        check("enable_main_clr", 32'h3F, rd);
        apb(1'b1, IDX_PRIORITY_AUX, 8'hFF);
        apb(1'b0, IDX_PRIORITY_AUX, 8'h00);
        check("priority_aux", 32'h08, rd);
        $display("test priority done");
    endtask : test_priority

    task automatic test_pins;
        apb(1'b1, IDX_TIMER_CONTROL, 8'h04);
        pin0 <= 1'b0;
        pin1 <= 1'b0;
        pin2 <= 1'b0;
        events <= '1;
        @(posedge sys_clk);
        events <= '0;
        repeat (4) @(posedge sys_clk);
        apb(1'b0, IDX_TIMER_CONTROL, 8'h00);
        check("tc_pins", 32'hAE, rd);
        apb(1'b0, IDX_PERIPH_FLAGS, 8'h00);
        check("pf_events", 32'h0F, rd);
        apb(1'b0, IDX_FLAG_AUX, 8'h00);
        check("conv_flag", 32'h08, rd);
        apb(1'b1, IDX_FLAG_AUX, 8'h00);
        apb(1'b1, IDX_TIMER_CONTROL, 8'h04);
        apb(1'b0, IDX_TIMER_CONTROL, 8'h00);
        check("level_holds", 32'h06, rd);
        pin0 <= 1'b1;
        pin1 <= 1'b1;
        pin2 <= 1'b1;
        repeat (3) @(posedge sys_clk);
        apb(1'b1, IDX_TIMER_CONTROL, 8'h04);
        apb(1'b0, IDX_TIMER_CONTROL, 8'h00);
        check("level_cleared", 32'h04, rd);
        mode3 <= 1'b1;
        apb(1'b1, IDX_ENABLE_MAIN, 8'h82);
        apb(1'b1, IDX_TIMER_CONTROL, 8'h20);
        wait_sig(1'b1);
        check("t0_src", {29'h0, SRC_TIMER0}, {29'h0, irq_seen.src});
        wait_sig(1'b0);
        apb(1'b0, IDX_TIMER_CONTROL, 8'h00);
        check("t0_mode3_kept", 32'h20, rd);
        apb(1'b1, IDX_ENABLE_MAIN, 8'h00);
        $display("test pins done");
    endtask : test_pins

    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : print_verdict

    initial begin
        #150000;
        fail_count++;
        print_verdict();
    end

    initial begin
        repeat (5) @(posedge sys_clk);
        sys_rst <= 1'b0;
        @(posedge sys_clk);
        test_reset();
        test_vectors();
        test_priority();
        test_pins();
        print_verdict();
    end
endmodule : interrupt_priority_controller_tb
